// ===== common/gds_pkg.sv
// Constants, carriers and state layout of the gate driver mode sequencer.
// Assumes a single 25 MHz clock; all times are converted to cycles here.
`default_nettype none

package gds_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned WAKE_DELAY_US = 1000;
  localparam int unsigned SLEEP_ENTRY_DELAY_US = 1000;
  localparam int unsigned RST_WINDOW_US = 20;
  localparam int unsigned GATE_DRIVE_TIMEOUT_NS = 4000;
  localparam int unsigned CNT_W = 20;
  // Least times round up to whole cycles
  localparam logic [CNT_W-1:0] WAKE_CYC_DEF =
    CNT_W'((WAKE_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SLEEP_CYC_DEF =
    CNT_W'((SLEEP_ENTRY_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] TMO_CYC =
    CNT_W'((GATE_DRIVE_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // The clearing window is a longest time and rounds down
  localparam logic [CNT_W-1:0] RST_CYC =
    CNT_W'((RST_WINDOW_US * 1000) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  // ==========================================================
  // Register map
  // ==========================================================
  localparam int unsigned REG_AW = 8;
  localparam logic [REG_AW-1:0] CTRL_OFS = 8'h00;
  localparam logic [REG_AW-1:0] STATUS_OFS = 8'h04;
  localparam int unsigned GATE_W = 6;
  localparam int unsigned SEL_W = 3;

  // ==========================================================
  // Types
  // ==========================================================
  // Mode sequence; the zero code is sleep
  typedef enum logic [2:0] {
    ST_SLEEP, ST_WAKE, ST_RUN, ST_CLR_LOW, ST_SHUTDOWN
  } gds_state_t;

  // Output stage mode; the zero code is the sleep pull-down
  typedef enum logic [1:0] {DRV_PULL, DRV_ON, DRV_HIZ} gds_drv_mode_t;

  // One bit per phase for each gate side
  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } gds_gate_t;

  // Status word as read by software
  typedef struct packed {
    logic [19:0] reserved;
    logic [SEL_W-1:0] drv_cap;
    logic [SEL_W-1:0] thr_cap;
    logic gate_fault;
    logic supply_uv;
    logic enable;
    gds_state_t state;
  } gds_status_t;

  // Complete state of the sequencer
  typedef struct packed {
    gds_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] tmo_cnt;
    logic gate_fault;
    logic [SEL_W-1:0] drv_cap;
    logic [SEL_W-1:0] thr_cap;
    gds_gate_t gate_req;
    gds_gate_t gate_out;
    gds_drv_mode_t mode;
    logic fault_drv;
    logic cp_en;
    logic ldo_en;
    logic ls_en;
    logic wr_ctrl;
    logic [31:0] rdata;
  } gds_regs_t;

  // All-zero reset: sleep, pull-down mode, every enable off
  localparam gds_regs_t REGS_RST = '0;

endpackage

`default_nettype wire

// ===== design/gds_sequencer.sv
// Sleep/wake mode sequencer of a three-phase gate driver with AHB-Lite
// registers. Assumes pins synchronous to hclk and a single-word master.
`default_nettype none

module gds_sequencer
  import gds_pkg::*;
#(
  parameter logic [CNT_W-1:0] WAKE_CYC = WAKE_CYC_DEF,
  parameter logic [CNT_W-1:0] SLEEP_CYC = SLEEP_CYC_DEF
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Mode and supply pins
  input wire logic enable_in,
  input wire logic supply_uv,
  // Strapped selections
  input wire logic [SEL_W-1:0] drive_strength_sel,
  input wire logic [SEL_W-1:0] drain_source_threshold_sel,
  // Gate level feedback, equal to the gate outputs once each gate reached its commanded level
  input wire gds_gate_t gate_level_fb,
  // Gate outputs
  output logic [2:0] high_gate_out,
  output logic [2:0] low_gate_out,
  output gds_drv_mode_t driver_mode,
  output logic [SEL_W-1:0] drive_strength_out,
  output logic [SEL_W-1:0] threshold_out,
  // Supply enables
  output logic charge_pump_en,
  output logic low_side_reg_en,
  output logic logic_supply_ldo_en,
  // Open-drain fault pin
  output logic fault_out_n_o,
  output logic fault_out_n_oe
);

  // ==========================================================
  // State
  // ==========================================================
  gds_regs_t q_reg; // Registered state
  gds_regs_t q_next; // Next state
  gds_gate_t gate_safe; // Request without shoot-through
  gds_status_t status; // Status word view
  logic drive_ok; // Gates may follow the request
  logic operating; // Running with good supply
  logic tmo_hit; // Gate transition timed out
  logic fault_clr; // Valid clearing pulse seen
  logic bus_acc; // Address phase taken
  logic [REG_AW-1:0] word_ofs; // Register offset of access

  // ==========================================================
  // Next-state logic
  // ==========================================================
  // Sequencer, gate watchdog, output stage and bus slave
  always_comb begin
    q_next = q_reg;
    tmo_hit = 1'b0;
    fault_clr = 1'b0;
    operating = (q_reg.st == ST_RUN) && !supply_uv;
    case (q_reg.st)
      ST_SLEEP: begin
        if (enable_in) begin
          q_next.st = ST_WAKE;
          q_next.cnt = '0;
        end
      end
      ST_WAKE: begin
        q_next.drv_cap = drive_strength_sel;
        q_next.thr_cap = drain_source_threshold_sel;
        if (!enable_in) begin
          // Dropped during wake, count entry delay from here
          q_next.st = ST_SHUTDOWN;
          q_next.cnt = '0;
        end else if (q_reg.cnt >= WAKE_CYC - CNT_ONE) begin
          q_next.st = ST_RUN;
          q_next.cnt = '0;
        end else begin
          q_next.cnt = q_reg.cnt + CNT_ONE;
        end
      end
      ST_RUN: begin
        // low enable enters the clearing window first
        // Falling edge: may be a clearing pulse or a sleep request
        if (!enable_in) begin
          q_next.st = ST_CLR_LOW;
          q_next.cnt = '0;
        end
      end
      ST_CLR_LOW: begin
        if (enable_in) begin
          q_next.st = ST_RUN;
          fault_clr = 1'b1;
        end else if (q_reg.cnt >= RST_CYC - CNT_ONE) begin
          q_next.st = ST_SHUTDOWN;
          q_next.cnt = q_reg.cnt + CNT_ONE;
        end else begin
          q_next.cnt = q_reg.cnt + CNT_ONE;
        end
      end
      ST_SHUTDOWN: begin
        if (enable_in) begin
          q_next.st = ST_WAKE;
          q_next.cnt = '0;
        end else if (q_reg.cnt >= SLEEP_CYC - CNT_ONE) begin
          q_next.st = ST_SLEEP;
          q_next.cnt = '0;
        end else begin
          q_next.cnt = q_reg.cnt + CNT_ONE;
        end
      end
      default: begin
        q_next.st = ST_SLEEP;
        q_next.cnt = '0;
      end
    endcase

    if (operating && !q_reg.gate_fault && (q_reg.gate_out != gate_level_fb)) begin
      if (q_reg.tmo_cnt >= TMO_CYC - CNT_ONE) begin
        tmo_hit = 1'b1;
        q_next.tmo_cnt = '0;
      end else begin
        q_next.tmo_cnt = q_reg.tmo_cnt + CNT_ONE;
      end
    end else begin
      q_next.tmo_cnt = '0;
    end
    // clear only the fault; a new timeout wins over the clear
    // A full shutdown into sleep also drops the latched fault
    q_next.gate_fault = tmo_hit |
                        (q_reg.gate_fault & ~fault_clr & (q_next.st != ST_SLEEP));

    // Never drive both gates of one phase
    gate_safe.high = q_reg.gate_req.high & ~q_reg.gate_req.low;
    gate_safe.low = q_reg.gate_req.low & ~q_reg.gate_req.high;
    drive_ok = (q_next.st == ST_RUN) && !supply_uv && !q_next.gate_fault;
    q_next.gate_out = drive_ok ? gate_safe : '0;
    if ((q_next.st == ST_SLEEP) || supply_uv) begin
      q_next.mode = DRV_PULL;
    end else if (!drive_ok) begin
      q_next.mode = DRV_HIZ;
    end else begin
      q_next.mode = DRV_ON;
    end

    q_next.ldo_en = (q_next.st != ST_SLEEP);
    q_next.ls_en = (q_next.st != ST_SLEEP);
    q_next.cp_en = (q_next.st != ST_SLEEP) && !supply_uv;
    q_next.fault_drv = (q_next.st == ST_WAKE) || (q_next.st == ST_SHUTDOWN) ||
                       q_next.gate_fault || ((q_next.st != ST_SLEEP) && supply_uv);

    // Status word
    status = '0;
    status.state = q_reg.st;
    status.enable = enable_in;
    status.supply_uv = supply_uv;
    status.gate_fault = q_reg.gate_fault;
    status.thr_cap = q_reg.thr_cap;
    status.drv_cap = q_reg.drv_cap;

    // Write data phase lands in the control register
    q_next.wr_ctrl = 1'b0;
    if (q_reg.wr_ctrl) begin
      q_next.gate_req = gds_gate_t'(hwdata[GATE_W-1:0]);
    end
    bus_acc = hsel && hready && htrans[1];
    word_ofs = {haddr[REG_AW-1:2], 2'b00};
    if (bus_acc) begin
      if (hwrite) begin
        q_next.wr_ctrl = (word_ofs == CTRL_OFS);
      end else if (word_ofs == CTRL_OFS) begin
        // Forward a write still in its data phase
        q_next.rdata = {{(32 - GATE_W){1'b0}},
                        (q_reg.wr_ctrl ? hwdata[GATE_W-1:0] : q_reg.gate_req)};
      end else if (word_ofs == STATUS_OFS) begin
        q_next.rdata = status;
      end else begin
        // Unmapped reads as zero
        q_next.rdata = '0;
      end
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  // Whole state in one flop bank
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_reg <= REGS_RST;
    end else begin
      q_reg <= q_next;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q_reg.rdata;
  assign high_gate_out = q_reg.gate_out.high;
  assign low_gate_out = q_reg.gate_out.low;
  assign driver_mode = q_reg.mode;
  assign drive_strength_out = q_reg.drv_cap;
  assign threshold_out = q_reg.thr_cap;
  assign charge_pump_en = q_reg.cp_en;
  assign low_side_reg_en = q_reg.ls_en;
  assign logic_supply_ldo_en = q_reg.ldo_en;
  // Open drain: only ever pulls low
  assign fault_out_n_o = 1'b0;
  assign fault_out_n_oe = q_reg.fault_drv;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_sleep_entry;
    (q_reg.st == ST_SHUTDOWN) && !enable_in && (q_reg.cnt == SLEEP_CYC - CNT_ONE)
      |=> (q_reg.st == ST_SLEEP) && (driver_mode == DRV_PULL);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep not entered at end of entry delay");

  property p_sleep_off;
    (q_reg.st == ST_SLEEP) |-> !charge_pump_en && !logic_supply_ldo_en &&
      (high_gate_out == 3'h0) && (low_gate_out == 3'h0) && !fault_out_n_oe;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("sleep left a supply or gate on");

  property p_low_sleeps;
    (q_reg.st == ST_RUN) && !enable_in ##1 !enable_in [*2]
      |-> (q_reg.st == ST_CLR_LOW) && (q_reg.cnt == CNT_ONE);
  endproperty
  a_low_sleeps: assert property (p_low_sleeps)
    else $error("low enable did not start shutdown timing");

  property p_wake;
    (q_reg.st == ST_SLEEP) && enable_in |=> (q_reg.st == ST_WAKE) && fault_out_n_oe;
  endproperty
  a_wake: assert property (p_wake)
    else $error("high enable did not wake the device");

  property p_uv_pull;
    supply_uv && (q_reg.st == ST_RUN) |=> (driver_mode == DRV_PULL) && !charge_pump_en;
  endproperty
  a_uv_pull: assert property (p_uv_pull)
    else $error("undervoltage did not select pull-downs");

  property p_wake_quiet;
    (q_reg.st == ST_WAKE) |-> fault_out_n_oe && (high_gate_out == 3'h0) &&
      (low_gate_out == 3'h0) && (q_reg.cnt < WAKE_CYC);
  endproperty
  a_wake_quiet: assert property (p_wake_quiet)
    else $error("wake interval drove a gate or released fault");

  property p_settings_hold;
    (q_reg.st == ST_RUN) ##1 (q_reg.st != ST_WAKE) |-> $stable(drive_strength_out) &&
      $stable(threshold_out);
  endproperty
  a_settings_hold: assert property (p_settings_hold)
    else $error("captured selection changed outside wake");

  property p_fault_hiz;
    q_reg.gate_fault && !supply_uv && (q_reg.st != ST_SLEEP)
      |-> (driver_mode == DRV_HIZ) && fault_out_n_oe && (high_gate_out == 3'h0);
  endproperty
  a_fault_hiz: assert property (p_fault_hiz)
    else $error("latched fault left drivers active");

  property p_timeout;
    operating && !q_reg.gate_fault && (q_reg.gate_out != gate_level_fb) &&
      (q_reg.tmo_cnt == TMO_CYC - CNT_ONE) |=> q_reg.gate_fault ##1 fault_out_n_oe;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("gate timeout did not raise fault");

  property p_clear_only;
    (q_reg.st == ST_CLR_LOW) && enable_in && !tmo_hit |=> (q_reg.st == ST_RUN) &&
      !q_reg.gate_fault && $stable(drive_strength_out) && logic_supply_ldo_en;
  endproperty
  a_clear_only: assert property (p_clear_only)
    else $error("clearing pulse did more than clear the fault");

endmodule // gds_sequencer

`default_nettype wire

// ===== test/gds_ctrl_model.sv
// Controller model: drives the enable pin and returns gate level feedback.
// Assumes enable is sampled on rising hclk and the fault pin is pulled up.
`default_nettype none
module gds_ctrl_model
  import gds_pkg::*;
(
  // Clock
  input wire logic hclk,
  // Pins seen from the controller
  input wire logic fault_line,
  input wire logic [2:0] high_gate_out,
  input wire logic [2:0] low_gate_out,
  output logic enable_in,
  output gds_gate_t gate_level_fb
);
  timeunit 1ns;
  timeprecision 1ns;
  logic stuck; // Gate refuses to follow its command
  initial begin
    enable_in = 1'b0;
    stuck = 1'b0;
  end
  // ==========================================================
  // Gate feedback, one cycle behind, inverted while stuck
  // ==========================================================
  always @(posedge hclk) begin
    gate_level_fb <= stuck ? ~{high_gate_out, low_gate_out} : {high_gate_out, low_gate_out};
  end
  // Move enable just after a rising edge
  task automatic set_en(input logic v);
    @(posedge hclk);
    enable_in <= v;
  endtask
  task automatic wake();
    set_en(1'b1);
    repeat (2) @(posedge hclk);
    while (fault_line !== 1'b1) @(posedge hclk);
  endtask
  task automatic clear_pulse(input int low_n);
    set_en(1'b0);
    repeat (low_n) @(posedge hclk);
    enable_in <= 1'b1;
  endtask
endmodule // gds_ctrl_model
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench of the mode sequencer with an AHB-Lite master.
// Assumes short wake and sleep counts set at the instance below.
`default_nettype none
module tb_top;
  import gds_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WAKE_N = 20;
  localparam int SLEEP_N = 600;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, supply_uv, enable_in;
  logic charge_pump_en, low_side_reg_en, logic_supply_ldo_en, fo_o, fo_oe, fault_line;
  logic [1:0] htrans;
  logic [2:0] hsize, high_gate_out, low_gate_out, drv_sel, thr_sel, drv_out, thr_out;
  logic [31:0] haddr, hwdata, hrdata, rd;
  gds_gate_t gate_fb;
  gds_drv_mode_t driver_mode;
  int error_cnt = 0;
  int checked = 0;
  // Open-drain fault pin with pull-up
  assign fault_line = fo_oe ? fo_o : 1'b1;
  gds_sequencer #(.WAKE_CYC(CNT_W'(WAKE_N)), .SLEEP_CYC(CNT_W'(SLEEP_N))) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .enable_in(enable_in),
    .supply_uv(supply_uv), .drive_strength_sel(drv_sel),
    .drain_source_threshold_sel(thr_sel), .gate_level_fb(gate_fb),
    .high_gate_out(high_gate_out), .low_gate_out(low_gate_out),
    .driver_mode(driver_mode), .drive_strength_out(drv_out), .threshold_out(thr_out),
    .charge_pump_en(charge_pump_en), .low_side_reg_en(low_side_reg_en),
    .logic_supply_ldo_en(logic_supply_ldo_en), .fault_out_n_o(fo_o),
    .fault_out_n_oe(fo_oe));
  gds_ctrl_model u_ctrl (.hclk(hclk), .fault_line(fault_line),
    .high_gate_out(high_gate_out), .low_gate_out(low_gate_out),
    .enable_in(enable_in), .gate_level_fb(gate_fb));
  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One AHB single transfer, address then data phase
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= wr; hsize <= 3'b010;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  // Outputs of a sleeping or supply-locked device
  task automatic chk_off(input gds_drv_mode_t m);
    @(negedge hclk);
    chk("mode", driver_mode, m);
    chk("gates", {high_gate_out, low_gate_out}, 32'h0);
    chk("pump", charge_pump_en, 1'b0);
  endtask
  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_wake();
    int k;
    drv_sel <= 3'h5; thr_sel <= 3'h2;
    u_ctrl.set_en(1'b1);
    @(posedge hclk);
    @(negedge hclk);
    chk("wake_fault", fault_line, 1'b0);
    chk("wake_regs", {charge_pump_en, low_side_reg_en, logic_supply_ldo_en}, 3'h7);
    chk("wake_mode", driver_mode, DRV_HIZ);
    for (k = 1; k < 60 && fault_line === 1'b0; k++) @(negedge hclk);
    chk("wake_len", (k >= WAKE_N - 1) && (k <= WAKE_N + 1), 1'b1);
    chk("run_mode", driver_mode, DRV_ON);
    @(posedge hclk);
    drv_sel <= 3'h1; thr_sel <= 3'h6;
    repeat (4) @(negedge hclk);
    chk("cap", {drv_out, thr_out}, 6'h2a);
    ahb(1'b0, 32'h4, 32'h0);
    chk("status", rd, 32'h00000a8a);
  endtask
  task automatic t_gates();
    ahb(1'b1, 32'h0, 32'h21);
    ahb(1'b0, 32'h0, 32'h0);
    chk("ctrl_rd", rd, 32'h21);
    chk("hresp", hresp, 1'b0);
    chk("gates_run", {high_gate_out, low_gate_out}, 6'h21);
    ahb(1'b0, 32'h10, 32'h0);
    chk("unmapped", rd, 32'h0);
  endtask
  task automatic t_gate_fault();
    int k;
    u_ctrl.stuck <= 1'b1;
    ahb(1'b1, 32'h0, 32'h02);
    for (k = 0; k < 200 && fault_line !== 1'b0; k++) @(negedge hclk);
    chk("tmo_len", k <= int'(TMO_CYC) + 8, 1'b1);
    chk("gdf_gates", {high_gate_out, low_gate_out}, 32'h0);
    chk("gdf_mode", driver_mode, DRV_HIZ);
    ahb(1'b0, 32'h4, 32'h0);
    chk("gdf_bit", rd[5], 1'b1);
    ahb(1'b1, 32'h0, 32'h0);
    u_ctrl.stuck <= 1'b0;
    u_ctrl.clear_pulse(10);
    repeat (4) @(negedge hclk);
    chk("clr_fault", fault_line, 1'b1);
    chk("clr_mode", driver_mode, DRV_ON);
    chk("clr_keep", {drv_out, thr_out, charge_pump_en}, 7'h55);
  endtask
  task automatic t_sleep();
    int k;
    u_ctrl.set_en(1'b0);
    repeat (int'(RST_CYC) + 6) @(negedge hclk);
    chk("shut_fault", fault_line, 1'b0);
    for (k = int'(RST_CYC) + 6; k < 900 && fault_line === 1'b0; k++) @(negedge hclk);
    chk("sleep_len", (k >= SLEEP_N - 2) && (k <= SLEEP_N + 2), 1'b1);
    chk_off(DRV_PULL);
    chk("ldo", logic_supply_ldo_en, 1'b0);
  endtask
  task automatic t_uv();
    u_ctrl.wake();
    repeat (2) @(negedge hclk);
    chk("recap", {drv_out, thr_out}, 6'h0e);
    @(posedge hclk);
    supply_uv <= 1'b1;
    repeat (2) @(posedge hclk);
    chk_off(DRV_PULL);
    chk("uv_fault", fault_line, 1'b0);
    @(posedge hclk);
    supply_uv <= 1'b0;
    repeat (4) @(negedge hclk);
    chk("uv_back", driver_mode, DRV_ON);
    // Shut down past the window, then rewake before sleep is reached
    u_ctrl.set_en(1'b0);
    repeat (int'(RST_CYC) + 6) @(negedge hclk);
    chk("rew_shut", fault_line, 1'b0);
    u_ctrl.wake();
    @(negedge hclk);
    chk("rew_mode", driver_mode, DRV_ON);
  endtask
  // ==========================================================
  // Clock, reset, sequence and verdict
  // ==========================================================
  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // Watchdog well beyond the under two thousand cycles needed
  initial begin
    #(40 * 20000);
    error_cnt++;
    print_verdict();
  end
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = '0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = '0; supply_uv = 1'b0; drv_sel = '0; thr_sel = '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    chk_off(DRV_PULL);
    ahb(1'b0, 32'h4, 32'h0);
    chk("rst_status", rd, 32'h0);
    t_wake();
    t_gates();
    t_gate_fault();
    t_sleep();
    t_uv();
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
